// [rtl/acc_analog_clock_control_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - Analog enable bit 5 powers second comparator.
// - Bits 3..0 enable measurement, voltage, B, A converters.
// - Measurement bit 0 set disables offset removal.
// - Supply detect disable bit turns detection off.
// - Regulator bits 5..3 pick auxiliary output voltage.
// - Regulator bits 2..0 trim the core supply.
// - Clock bit 7 enables PLL, bit 6 bandgap.
// - Clock bits 5..4 scale sample clock x1/x2/x4.
// - Clock bits 3..2 scale meter clock x1/x2/x4.
// - Clock bits 1..0 scale processor clock up to x8.
// - Boost bit 6 doubles the processor clock.
// - Boost bit 7 doubles again, only with bit 6.
module acc_analog_clock_control_regs #(
    parameter int ADDR_WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_WIDTH-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic [7:0] meas_input_ctrl_out,
    output logic comparator_b_enable,
    output logic meas_adc_enable,
    output logic voltage_adc_enable,
    output logic current_b_adc_enable,
    output logic current_a_adc_enable,
    output logic meas_offset_removal_off,
    output logic supply_detect_disable,
    output logic [2:0] aux_regulator_select,
    output logic [11:0] aux_regulator_mv,
    output logic [2:0] core_supply_trim,
    output logic signed [10:0] core_supply_trim_mv,
    output logic pll_enable,
    output logic bandgap_enable,
    output logic [1:0] sample_clock_select,
    output logic [1:0] meter_clock_select,
    output logic [1:0] cpu_clock_select,
    output logic cpu_clock_double,
    output logic cpu_clock_second_double,
    output logic grid_60hz_select,
    output logic [24:0] sample_clock_hz,
    output logic [24:0] meter_clock_hz,
    output logic [24:0] cpu_clock_hz,
    output logic pll_order_error,
    output logic clock_code_invalid
);

    // The offsets are sixteen-bit constants, so sixteen address bits are required
    initial
    begin
        if (ADDR_WIDTH < 16)
            $error("ADDR_WIDTH must be at least 16");
    end

    // Storage for the six control bytes
    acc_pkg::acc_byte_type meas_input_ctrl_reg;
    acc_pkg::acc_byte_type analog_enable_ctrl_reg;
    acc_pkg::acc_byte_type meas_channel_ctrl_reg;
    acc_pkg::acc_byte_type regulator_ctrl_reg;
    acc_pkg::acc_byte_type clock_ctrl_reg;
    acc_pkg::acc_byte_type cpu_clock_boost_ctrl_reg;
    // Sticky flag: PLL came up, or was left on, without bandgap
    logic order_error_reg;
    logic order_error_next;
    // Read return path
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    // Decoded analog settings
    logic [11:0] aux_mv_reg;
    logic signed [10:0] trim_mv_reg;

    // Address matches, wider addresses compared in full
    logic hit_meas_input;
    logic hit_analog_en;
    logic hit_meas_chan;
    logic hit_regulator;
    logic hit_clock;
    logic hit_boost;
    // Status byte is our own addition
    logic hit_status;

    // Offset padded to the address width so narrow offsets compare cleanly
    function automatic logic acc_match(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [15:0] ofs
    );
        acc_match = (addr == ADDR_WIDTH'(ofs));
    endfunction

    // Decode is shared by reads and writes
    always_comb
    begin
        hit_meas_input = acc_match(bus_addr, acc_pkg::ACC_OFS_MEAS_INPUT);
        hit_analog_en = acc_match(bus_addr, acc_pkg::ACC_OFS_ANALOG_EN);
        hit_meas_chan = acc_match(bus_addr, acc_pkg::ACC_OFS_MEAS_CHAN);
        hit_regulator = acc_match(bus_addr, acc_pkg::ACC_OFS_REGULATOR);
        hit_clock = acc_match(bus_addr, acc_pkg::ACC_OFS_CLOCK);
        hit_boost = acc_match(bus_addr, acc_pkg::ACC_OFS_BOOST);
        hit_status = acc_match(bus_addr, acc_pkg::ACC_OFS_STATUS);
    end

    // Auxiliary regulator code to millivolts
    // Shared by reset and run paths
    function automatic logic [11:0] acc_aux_mv(input logic [2:0] code);
        unique case (code)
            3'h0: acc_aux_mv = 12'hCE4; // 3.3 V
            3'h1: acc_aux_mv = 12'hC80; // 3.2 V
            3'h3: acc_aux_mv = 12'hD48; // 3.4 V
            3'h6: acc_aux_mv = 12'hC1C; // 3.1 V
            3'h7: acc_aux_mv = 12'hBB8; // 3.0 V
            default: acc_aux_mv = 12'hDAC; // 2, 4 and 5 all give 3.5 V
        endcase
    endfunction

    // Core supply trim code to signed millivolts
    function automatic logic signed [10:0] acc_trim_mv(input logic [2:0] code);
        unique case (code)
            3'h0: acc_trim_mv = 11'sh000; // No offset
            3'h1: acc_trim_mv = -11'sh064; // Minus 0.1 V
            3'h2: acc_trim_mv = 11'sh0C8; // Plus 0.2 V
            3'h3: acc_trim_mv = 11'sh064; // Plus 0.1 V
            3'h4: acc_trim_mv = -11'sh190; // Minus 0.4 V
            3'h5: acc_trim_mv = -11'sh1F4; // Minus 0.5 V
            3'h6: acc_trim_mv = -11'sh0C8; // Minus 0.2 V
            3'h7: acc_trim_mv = -11'sh12C; // Minus 0.3 V
        endcase
    endfunction

    // Measurement input selection, gain and divider
    // Held as written; the analog mux decodes it outside
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            meas_input_ctrl_reg <= acc_pkg::ACC_RST_MEAS_INPUT;
        else if (bus_wr && hit_meas_input)
            meas_input_ctrl_reg <= bus_wdata;
    end

    // Comparator and converter power enables
    // Reserved bits are stored too, so reads echo writes
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            analog_enable_ctrl_reg <= acc_pkg::ACC_RST_ANALOG_EN;
        else if (bus_wr && hit_analog_en)
            analog_enable_ctrl_reg <= bus_wdata;
    end

    // Measurement channel offset removal control
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            meas_channel_ctrl_reg <= acc_pkg::ACC_RST_MEAS_CHAN;
        else if (bus_wr && hit_meas_chan)
            meas_channel_ctrl_reg <= bus_wdata;
    end

    // Supply detection and regulator trims
    // Detection stays on after reset, the safe choice at 5 V
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            regulator_ctrl_reg <= acc_pkg::ACC_RST_REGULATOR;
        else if (bus_wr && hit_regulator)
            regulator_ctrl_reg <= bus_wdata;
    end

    // PLL, bandgap and clock rate selection
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            clock_ctrl_reg <= acc_pkg::ACC_RST_CLOCK;
        else if (bus_wr && hit_clock)
            clock_ctrl_reg <= bus_wdata;
    end

    // Processor clock doubling and grid frequency select
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            cpu_clock_boost_ctrl_reg <= acc_pkg::ACC_RST_BOOST;
        else if (bus_wr && hit_boost)
            cpu_clock_boost_ctrl_reg <= bus_wdata;
    end

    // Watch the bandgap-then-PLL order software must keep
    // The block does not refuse a bad order; it only reports it
    always_comb
    begin
        order_error_next = order_error_reg;
        // Write one to clear
        if (bus_wr && hit_status && bus_wdata[acc_pkg::ACC_ST_ORDER_BIT])
            order_error_next = 1'b0;
        // A new violation wins over a clear in the same cycle
        if (bus_wr && hit_clock)
        begin
            // PLL on while bandgap was off before this write
            if (bus_wdata[acc_pkg::ACC_PLL_EN_BIT]
                && !clock_ctrl_reg[acc_pkg::ACC_PLL_EN_BIT]
                && !clock_ctrl_reg[acc_pkg::ACC_BANDGAP_BIT])
                order_error_next = 1'b1;
            // Bandgap dropped under a running PLL
            if (bus_wdata[acc_pkg::ACC_PLL_EN_BIT]
                && !bus_wdata[acc_pkg::ACC_BANDGAP_BIT])
                order_error_next = 1'b1;
        end
    end

    // Order flag storage
    // Cleared only by reset or software
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            order_error_reg <= 1'b0;
        else
            order_error_reg <= order_error_next;
    end

    // Registered decode of the regulator fields
    // One cycle behind the register, harmless for trims
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            aux_mv_reg <= acc_aux_mv(3'h0);
            trim_mv_reg <= acc_trim_mv(3'h0);
        end
        else
        begin
            aux_mv_reg <= acc_aux_mv(aux_regulator_select);
            trim_mv_reg <= acc_trim_mv(core_supply_trim);
        end
    end

    // Rate decoder lives in its own module
    // Bundle kept local to this block
    acc_clk_if cif ();

    // Selections handed to the decoder
    always_comb
    begin
        cif.sample_sel = sample_clock_select;
        cif.meter_sel = meter_clock_select;
        cif.cpu_sel = cpu_clock_select;
        cif.cpu_double = cpu_clock_double;
        cif.cpu_second_double = cpu_clock_second_double;
    end

    // Rates land one edge after the write edge
    acc_clock_ratio u_ratio (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cif(cif.ratio)
    );

    // Read mux; unmapped addresses read as zero
    always_comb
    begin
        rdata_next = 8'h00;
        // No strobe, no data
        if (bus_rd)
        begin
            if (hit_meas_input)
                rdata_next = meas_input_ctrl_reg;
            else if (hit_analog_en)
                rdata_next = analog_enable_ctrl_reg;
            else if (hit_meas_chan)
                rdata_next = meas_channel_ctrl_reg;
            else if (hit_regulator)
                rdata_next = regulator_ctrl_reg;
            else if (hit_clock)
                rdata_next = clock_ctrl_reg;
            else if (hit_boost)
                rdata_next = cpu_clock_boost_ctrl_reg;
            else if (hit_status)
            begin
                // Status shows the block's own state
                rdata_next[acc_pkg::ACC_ST_ORDER_BIT] = order_error_reg;
                rdata_next[acc_pkg::ACC_ST_CODE_BIT] = cif.code_invalid;
            end
        end
    end

    // Read data stands for the one cycle after the strobe
    // No wait states on either strobe
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    // Register fields straight out to the analog side
    always_comb
    begin
        // Bus side
        bus_rdata = rdata_reg;
        // Analog side, from storage
        meas_input_ctrl_out = meas_input_ctrl_reg;
        comparator_b_enable = analog_enable_ctrl_reg[acc_pkg::ACC_COMPB_BIT];
        meas_adc_enable = analog_enable_ctrl_reg[acc_pkg::ACC_MEAS_ADC_BIT];
        voltage_adc_enable = analog_enable_ctrl_reg[acc_pkg::ACC_VOLT_ADC_BIT];
        current_b_adc_enable = analog_enable_ctrl_reg[acc_pkg::ACC_CURB_ADC_BIT];
        current_a_adc_enable = analog_enable_ctrl_reg[acc_pkg::ACC_CURA_ADC_BIT];
        // Set means offset removal off
        meas_offset_removal_off = meas_channel_ctrl_reg[acc_pkg::ACC_OFFSET_OFF_BIT];
        supply_detect_disable = regulator_ctrl_reg[acc_pkg::ACC_SUPPLY_DET_BIT];
        aux_regulator_select = regulator_ctrl_reg[acc_pkg::ACC_AUX_SEL_LSB +: 3];
        core_supply_trim = regulator_ctrl_reg[acc_pkg::ACC_TRIM_LSB +: 3];
        aux_regulator_mv = aux_mv_reg;
        core_supply_trim_mv = trim_mv_reg;
        pll_enable = clock_ctrl_reg[acc_pkg::ACC_PLL_EN_BIT];
        bandgap_enable = clock_ctrl_reg[acc_pkg::ACC_BANDGAP_BIT];
        sample_clock_select = clock_ctrl_reg[acc_pkg::ACC_SAMPLE_SEL_LSB +: 2];
        meter_clock_select = clock_ctrl_reg[acc_pkg::ACC_METER_SEL_LSB +: 2];
        cpu_clock_select = clock_ctrl_reg[acc_pkg::ACC_CPU_SEL_LSB +: 2];
        cpu_clock_double = cpu_clock_boost_ctrl_reg[acc_pkg::ACC_DOUBLE_BIT];
        // Second doubling is qualified by the first
        cpu_clock_second_double = cpu_clock_boost_ctrl_reg[acc_pkg::ACC_SECOND_DOUBLE_BIT]
            & cpu_clock_boost_ctrl_reg[acc_pkg::ACC_DOUBLE_BIT];
        grid_60hz_select = cpu_clock_boost_ctrl_reg[acc_pkg::ACC_GRID_BIT];
        // Rates from the decoder
        sample_clock_hz = cif.sample_hz;
        meter_clock_hz = cif.meter_hz;
        cpu_clock_hz = cif.cpu_hz;
        // Status flags
        pll_order_error = order_error_reg;
        clock_code_invalid = cif.code_invalid;
    end

endmodule // acc_analog_clock_control_regs

// [rtl/acc_pkg.sv]
package acc_pkg;
    // Byte registers; addresses are the printed offsets
    typedef logic [7:0] acc_byte_type;
    localparam logic [15:0] ACC_OFS_MEAS_INPUT = 16'h2863;
    localparam logic [15:0] ACC_OFS_ANALOG_EN = 16'h2864;
    localparam logic [15:0] ACC_OFS_MEAS_CHAN = 16'h2865;
    localparam logic [15:0] ACC_OFS_REGULATOR = 16'h2866;
    localparam logic [15:0] ACC_OFS_CLOCK = 16'h2867;
    localparam logic [15:0] ACC_OFS_BOOST = 16'h2868;
    localparam logic [15:0] ACC_OFS_STATUS = 16'h2869;
    // Reset values
    localparam acc_byte_type ACC_RST_MEAS_INPUT = 8'h00;
    localparam acc_byte_type ACC_RST_ANALOG_EN = 8'h00;
    localparam acc_byte_type ACC_RST_MEAS_CHAN = 8'h00;
    localparam acc_byte_type ACC_RST_REGULATOR = 8'h00;
    localparam acc_byte_type ACC_RST_CLOCK = 8'h00;
    localparam acc_byte_type ACC_RST_BOOST = 8'h00;
    // Field positions
    localparam int ACC_COMPB_BIT = 5;
    localparam int ACC_MEAS_ADC_BIT = 3;
    localparam int ACC_VOLT_ADC_BIT = 2;
    localparam int ACC_CURB_ADC_BIT = 1;
    localparam int ACC_CURA_ADC_BIT = 0;
    localparam int ACC_OFFSET_OFF_BIT = 0;
    localparam int ACC_SUPPLY_DET_BIT = 7;
    localparam int ACC_AUX_SEL_LSB = 3;
    localparam int ACC_TRIM_LSB = 0;
    localparam int ACC_PLL_EN_BIT = 7;
    localparam int ACC_BANDGAP_BIT = 6;
    localparam int ACC_SAMPLE_SEL_LSB = 4;
    localparam int ACC_METER_SEL_LSB = 2;
    localparam int ACC_CPU_SEL_LSB = 0;
    localparam int ACC_SECOND_DOUBLE_BIT = 7;
    localparam int ACC_DOUBLE_BIT = 6;
    localparam int ACC_GRID_BIT = 5;
    localparam int ACC_ST_ORDER_BIT = 0;
    localparam int ACC_ST_CODE_BIT = 1;
    // Base clock rates in Hz
    localparam logic [24:0] ACC_SAMPLE_BASE_HZ = 25'h0032000;
    localparam logic [24:0] ACC_METER_BASE_HZ = 25'h00C8000;
    localparam logic [24:0] ACC_CPU_BASE_HZ = 25'h00C8000;
endpackage

// [rtl/acc_clk_if.sv]
`timescale 1ns/1ps
// Clock selections from the register bank to the rate decoder
interface acc_clk_if;
    logic [1:0] sample_sel;
    logic [1:0] meter_sel;
    logic [1:0] cpu_sel;
    logic cpu_double;
    logic cpu_second_double;
    logic [24:0] sample_hz;
    logic [24:0] meter_hz;
    logic [24:0] cpu_hz;
    logic code_invalid;
    modport regs (output sample_sel, meter_sel, cpu_sel, cpu_double, cpu_second_double,
        input sample_hz, meter_hz, cpu_hz, code_invalid);
    modport ratio (input sample_sel, meter_sel, cpu_sel, cpu_double, cpu_second_double,
        output sample_hz, meter_hz, cpu_hz, code_invalid);
endinterface

// [rtl/acc_clock_ratio.sv]
`timescale 1ns/1ps
// Turns clock select codes into resulting rates in Hz
module acc_clock_ratio (
    input wire logic clk_sys,
    input wire logic sys_rst,
    acc_clk_if.ratio cif
);
    // Three-way select: code 11 has no meaning, held at x4
    function automatic logic [1:0] acc_shift3(input logic [1:0] sel);
        acc_shift3 = (sel == 2'h3) ? 2'h2 : sel;
    endfunction

    logic [2:0] cpu_shift;
    always_comb
    begin
        // Doublings stack on the selected multiplier
        cpu_shift = {1'b0, cif.cpu_sel} + {2'h0, cif.cpu_double}
            + {2'h0, cif.cpu_double & cif.cpu_second_double};
    end

    // Rates are registered so outputs come from flip-flops
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cif.sample_hz <= acc_pkg::ACC_SAMPLE_BASE_HZ;
            cif.meter_hz <= acc_pkg::ACC_METER_BASE_HZ;
            cif.cpu_hz <= acc_pkg::ACC_CPU_BASE_HZ;
            cif.code_invalid <= 1'b0;
        end
        else
        begin
            cif.sample_hz <= acc_pkg::ACC_SAMPLE_BASE_HZ << acc_shift3(cif.sample_sel);
            cif.meter_hz <= acc_pkg::ACC_METER_BASE_HZ << acc_shift3(cif.meter_sel);
            cif.cpu_hz <= acc_pkg::ACC_CPU_BASE_HZ << cpu_shift;
            cif.code_invalid <= (cif.sample_sel == 2'h3) | (cif.meter_sel == 2'h3);
        end
    end
endmodule // acc_clock_ratio

// [verification/acc_regs_properties.sv]
`timescale 1ns/1ps
// Port-level checks for the control bank
module acc_regs_properties #(
    parameter int ADDR_WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_WIDTH-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic comparator_b_enable,
    input wire logic meas_adc_enable,
    input wire logic voltage_adc_enable,
    input wire logic current_b_adc_enable,
    input wire logic current_a_adc_enable,
    input wire logic meas_offset_removal_off,
    input wire logic supply_detect_disable,
    input wire logic [2:0] aux_regulator_select,
    input wire logic [11:0] aux_regulator_mv,
    input wire logic [2:0] core_supply_trim,
    input wire logic signed [10:0] core_supply_trim_mv,
    input wire logic pll_enable,
    input wire logic bandgap_enable,
    input wire logic [1:0] sample_clock_select,
    input wire logic [1:0] meter_clock_select,
    input wire logic [1:0] cpu_clock_select,
    input wire logic cpu_clock_double,
    input wire logic cpu_clock_second_double,
    input wire logic [24:0] sample_clock_hz,
    input wire logic [24:0] meter_clock_hz,
    input wire logic [24:0] cpu_clock_hz,
    input wire logic clock_code_invalid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Expected voltages per code, in millivolts
    localparam logic [11:0] AUX_MV [8] = '{12'hCE4, 12'hC80, 12'hDAC, 12'hD48, 12'hDAC, 12'hDAC, 12'hC1C, 12'hBB8};
    localparam logic [10:0] TRIM_MV [8] = '{11'h000, 11'h79C, 11'h0C8, 11'h064, 11'h670, 11'h60C, 11'h738, 11'h6D4};
    // Write hit per register, lowest address first
    logic [5:0] wr_hit;
    // Decoded once here
    always_comb
    begin
        for (int i = 0; i < 6; i++)
            wr_hit[i] = bus_wr && bus_addr == ADDR_WIDTH'(acc_pkg::ACC_OFS_MEAS_INPUT + 16'(i));
    end
    // Selections steady while the rates settle
    sequence s_clk_steady;
        $stable({sample_clock_select, meter_clock_select, cpu_clock_select, cpu_clock_double,
            cpu_clock_second_double})[*3];
    endsequence
    sequence s_reg_steady;
        $stable({aux_regulator_select, core_supply_trim})[*2];
    endsequence
    property p_comp_b; wr_hit[1] |=> comparator_b_enable == $past(bus_wdata[5]); endproperty
    a_comp_b: assert property (p_comp_b) else $error("comparator enable not taken from write");
    property p_adcs; wr_hit[1] |=> {meas_adc_enable, voltage_adc_enable, current_b_adc_enable,
        current_a_adc_enable} == $past(bus_wdata[3:0]); endproperty
    a_adcs: assert property (p_adcs) else $error("converter enables out of order");
    property p_offset; wr_hit[2] |=> meas_offset_removal_off == $past(bus_wdata[0]); endproperty
    a_offset: assert property (p_offset) else $error("offset removal bit wrong");
    property p_supply; wr_hit[3] |=> supply_detect_disable == $past(bus_wdata[7]); endproperty
    a_supply: assert property (p_supply) else $error("supply detect bit wrong");
    property p_aux; s_reg_steady |-> aux_regulator_mv == AUX_MV[aux_regulator_select]; endproperty
    a_aux: assert property (p_aux) else $error("aux regulator voltage wrong");
    property p_trim; s_reg_steady |-> $unsigned(core_supply_trim_mv) == TRIM_MV[core_supply_trim]; endproperty
    a_trim: assert property (p_trim) else $error("core trim voltage wrong");
    property p_pll_bg; wr_hit[4] |=> {pll_enable, bandgap_enable} == $past(bus_wdata[7:6]); endproperty
    a_pll_bg: assert property (p_pll_bg) else $error("pll or bandgap enable wrong");
    property p_sample; s_clk_steady |-> sample_clock_hz == (acc_pkg::ACC_SAMPLE_BASE_HZ
        << (sample_clock_select == 2'h3 ? 2 : sample_clock_select)); endproperty
    a_sample: assert property (p_sample) else $error("sample clock rate wrong");
    property p_meter; s_clk_steady |-> meter_clock_hz == (acc_pkg::ACC_METER_BASE_HZ
        << (meter_clock_select == 2'h3 ? 2 : meter_clock_select)); endproperty
    a_meter: assert property (p_meter) else $error("meter clock rate wrong");
    property p_cpu; s_clk_steady |-> cpu_clock_hz == (acc_pkg::ACC_CPU_BASE_HZ << (3'(cpu_clock_select)
        + 3'(cpu_clock_double) + 3'(cpu_clock_second_double))); endproperty
    a_cpu: assert property (p_cpu) else $error("cpu clock rate wrong");
    property p_double; wr_hit[5] |=> cpu_clock_double == $past(bus_wdata[6]); endproperty
    a_double: assert property (p_double) else $error("first doubling bit wrong");
    property p_second; wr_hit[5] |=> cpu_clock_second_double == ($past(bus_wdata[7]) && $past(bus_wdata[6]));
    endproperty
    a_second: assert property (p_second) else $error("second doubling not gated");
    property p_readback; bus_rd && bus_addr == ADDR_WIDTH'(acc_pkg::ACC_OFS_CLOCK) |=> bus_rdata == $past(
        {pll_enable, bandgap_enable, sample_clock_select, meter_clock_select, cpu_clock_select}); endproperty
    a_readback: assert property (p_readback) else $error("clock register read back wrong");
    // Never disabled: reset is the cause
    property p_reset; @(posedge clk_sys) disable iff (1'b0) sys_rst |=> !pll_enable && !bandgap_enable
        && !comparator_b_enable && !cpu_clock_double && bus_rdata == 8'h00; endproperty
    a_reset: assert property (p_reset) else $error("reset left a field set");
endmodule // acc_regs_properties

// [verification/analog_clock_control_regs_tb.sv]
`timescale 1ns/1ps
// Self-checking bench with a byte model of the six registers
module analog_clock_control_regs_tb;
    logic clk_sys = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, meas_input_ctrl_out;
    logic comparator_b_enable, meas_adc_enable, voltage_adc_enable, current_b_adc_enable, current_a_adc_enable;
    logic meas_offset_removal_off, supply_detect_disable, pll_enable, bandgap_enable, grid_60hz_select;
    logic [2:0] aux_regulator_select, core_supply_trim;
    logic [11:0] aux_regulator_mv;
    logic signed [10:0] core_supply_trim_mv;
    logic [1:0] sample_clock_select, meter_clock_select, cpu_clock_select;
    logic cpu_clock_double, cpu_clock_second_double, pll_order_error, clock_code_invalid;
    logic [24:0] sample_clock_hz, meter_clock_hz, cpu_clock_hz;
    int n_fail = 0, cmp_count = 0;
    // Model bytes, index 0 is the lowest address
    logic [7:0] mdl [6] = '{default: 8'h00};
    logic [11:0] aux_tab [8] = '{12'hCE4, 12'hC80, 12'hDAC, 12'hD48, 12'hDAC, 12'hDAC, 12'hC1C, 12'hBB8};
    logic [10:0] trim_tab [8] = '{11'h000, 11'h79C, 11'h0C8, 11'h064, 11'h670, 11'h60C, 11'h738, 11'h6D4};
    // Bits software may set; reserved ones stay zero
    logic [7:0] msk [6] = '{8'h37, 8'h2F, 8'h01, 8'hBF, 8'hFF, 8'hE0};
    always #20 clk_sys = ~clk_sys;
    acc_analog_clock_control_regs u_dut (.*);
    // One comparison, counted and reported on mismatch
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Code 3 of the sample and meter selects runs as x4
    function automatic int sh(input logic [1:0] c);
        return (c == 2'h3) ? 2 : int'(c);
    endfunction
    // One-cycle write; model keeps mapped bytes
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        if (a >= 16'h2863 && a <= 16'h2868)
            mdl[int'(a - 16'h2863)] = d;
    endtask
    // Single-cycle read; data looked at in the following cycle only
    task automatic rd(input logic [15:0] a);
        logic [7:0] e;
        e = (a >= 16'h2863 && a <= 16'h2868) ? mdl[int'(a - 16'h2863)] : 8'h00;
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk("bus_rdata", e, bus_rdata);
    endtask
    // Settle the rate path, then compare all
    task automatic chk_all;
        logic d;
        repeat (3) @(posedge clk_sys);
        #1;
        d = mdl[5][6];
        chk("meas_input_ctrl_out", mdl[0], meas_input_ctrl_out);
        chk("comparator_b_enable", mdl[1][5], comparator_b_enable);
        chk("adc_enables", mdl[1][3:0], {meas_adc_enable, voltage_adc_enable, current_b_adc_enable,
            current_a_adc_enable});
        chk("meas_offset_removal_off", mdl[2][0], meas_offset_removal_off);
        chk("supply_detect_disable", mdl[3][7], supply_detect_disable);
        chk("aux_regulator_mv", aux_tab[mdl[3][5:3]], aux_regulator_mv);
        chk("core_supply_trim_mv", trim_tab[mdl[3][2:0]], $unsigned(core_supply_trim_mv));
        chk("pll_bandgap", mdl[4][7:6], {pll_enable, bandgap_enable});
        chk("sample_clock_hz", 32'h32000 << sh(mdl[4][5:4]), sample_clock_hz);
        chk("meter_clock_hz", 32'hC8000 << sh(mdl[4][3:2]), meter_clock_hz);
        chk("cpu_clock_hz", 32'hC8000 << (int'(mdl[4][1:0]) + int'(d) + int'(d & mdl[5][7])), cpu_clock_hz);
        chk("cpu_clock_second_double", d & mdl[5][7], cpu_clock_second_double);
        chk("grid_60hz_select", mdl[5][5], grid_60hz_select);
        chk("clock_code_invalid", mdl[4][5:4] == 2'h3 || mdl[4][3:2] == 2'h3, clock_code_invalid);
    endtask
    task automatic finish_test;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(76165));
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk_all();
        for (int a = 0; a < 6; a++)
            rd(16'h2863 + 16'(a));
        $display("Test reset values done");
        wr(16'h2C23, 8'h00);
        // Walk each enable alone; bit 4 is reserved and left zero
        for (int b = 0; b < 6; b++)
        begin
            wr(16'h2864, (b == 4) ? 8'h00 : 8'(1 << b));
            chk_all();
        end
        $display("Test analog enables done");
        // Every regulator code; detect and offset bits toggle
        for (int i = 0; i < 64; i++)
        begin
            wr(16'h2866, {i[0], 1'b0, 6'(i)});
            wr(16'h2865, {7'h00, i[1]});
            chk_all();
        end
        $display("Test regulator codes done");
        // Bandgap first, then the PLL, then every select and doubling pair
        wr(16'h2867, 8'h40);
        wr(16'h2867, 8'hC0);
        for (int i = 0; i < 256; i++)
        begin
            wr(16'h2867, {2'h3, 6'(i)});
            wr(16'h2868, {2'(i >> 6), 6'h00});
            chk_all();
        end
        chk("pll_order_error", 1'b0, pll_order_error);
        $display("Test clock selects done");
        // Random writes, about one in seven to an unmapped address, each read back
        for (int i = 0; i < 60; i++)
        begin
            logic [15:0] a;
            logic [7:0] d;
            a = ($urandom_range(0, 6) == 6) ? 16'h2870 : 16'h2863 + 16'($urandom_range(0, 5));
            d = 8'($urandom);
            if (a != 16'h2870)
                d &= msk[a - 16'h2863];
            if (a == 16'h2867)
                d[6] = 1'b1;
            wr(a, d);
            rd(a);
        end
        chk_all();
        $display("Test random access done");
        // Reset in mid-run clears every field
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        mdl = '{default: 8'h00};
        chk_all();
        for (int a = 0; a < 6; a++)
            rd(16'h2863 + 16'(a));
        $display("Test second reset done");
        finish_test();
    end
    // Watchdog: the run needs well under ten thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        finish_test();
    end
endmodule // analog_clock_control_regs_tb

bind acc_analog_clock_control_regs acc_regs_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.*);
